// ===== design/rtc_defs.vh
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

// register byte offsets
`define RTC_OFS_TIME 12'h000
`define RTC_OFS_CTRL 12'h004
`define RTC_OFS_ALARM 12'h008
`define RTC_OFS_SWATCH 12'h00c
`define RTC_OFS_STAT 12'h010
`define RTC_OFS_MASK 12'h014
`define RTC_OFS_WAKE 12'h018

// time word layout
`define RTC_SEC_LSB 0
`define RTC_SEC_MSB 5
`define RTC_MIN_LSB 6
`define RTC_MIN_MSB 11
`define RTC_HOUR_LSB 12
`define RTC_HOUR_MSB 16
`define RTC_DAY_LSB 17
`define RTC_DAY_MSB 31

// counter limits
`define RTC_SEC_LAST 6'h3b
`define RTC_MIN_LAST 6'h3b
`define RTC_HOUR_LAST 5'h17
`define RTC_DAY_LAST 15'h7fff

// control bits
`define RTC_CTRL_ALM_TOD 0
`define RTC_CTRL_ALM_DAY 1
`define RTC_CTRL_SW_EN 2
`define RTC_CTRL_W 3

// status / mask / wake bits
`define RTC_EV_SEC 0
`define RTC_EV_MIN 1
`define RTC_EV_HOUR 2
`define RTC_EV_DAY 3
`define RTC_EV_ALM_TOD 4
`define RTC_EV_ALM_DAY 5
`define RTC_EV_SW 6
`define RTC_EV_W 7

// reset values
`define RTC_RST_TIME 32'h00000000
`define RTC_RST_CTRL 3'h0
`define RTC_RST_ALARM 32'h00000000
`define RTC_RST_MASK 7'h00
`define RTC_RST_WAKE 7'h00

// crystal frequency in hz and prescale count for a 1 hz tick
`define RTC_XTAL_HZ 32768
`define RTC_TICK_HZ 1
`define RTC_PRESCALE (`RTC_XTAL_HZ / `RTC_TICK_HZ)

`endif

// ===== design/rtc_prescale.v
`timescale 1ns/1ps
`include "rtc_defs.vh"

module rtc_prescale #(
	parameter DIV = `RTC_PRESCALE
) (
	input wire clk, // system clock
	input wire rst_n, // async reset, active low
	input wire xtal_clk, // crystal clock level, sampled
	output reg tick // one-cycle 1 hz pulse
);

reg xtal_d_reg;
reg [31:0] cnt_reg;
wire xtal_rise;

assign xtal_rise = xtal_clk & ~xtal_d_reg;

// one tick per DIV crystal rising edges
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		xtal_d_reg <= 1'b0;
		cnt_reg <= 32'h00000000;
		tick <= 1'b0;
	end else begin
		xtal_d_reg <= xtal_clk;
		tick <= 1'b0;
		if (xtal_rise) begin
			if (cnt_reg == DIV - 1) begin
				cnt_reg <= 32'h00000000;
				tick <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + 32'h00000001;
			end
		end
	end
end

endmodule // rtc_prescale

// ===== design/rtc_top.v
// How it works
// - prescaler turns crystal into 1 hz tick
// - seconds and minutes count modulo sixty
// - hours modulo 24, days count 32768
// - per second/minute/hour/day interrupts, each maskable
// - enabled alarm fires when time equals setting
// - time-of-day alarm and day-plus-time alarm
// - stopwatch loaded, decrements on every 1 hz tick
// - enabled stopwatch interrupts on underflow
// - enabled events raise wakeup request
// - same wakeup ends deep sleep, hibernate
// - counting never depends on processor power state
`timescale 1ns/1ps
`include "rtc_defs.vh"

module rtc_top #(
	parameter PRESCALE = `RTC_PRESCALE,
	parameter SW_W = 16
) (
	input wire clk, // system clock, 20 mhz
	input wire rst_n, // async reset, active low
	input wire xtal_clk, // 32.768 khz crystal clock level
	input wire psel, // apb select
	input wire penable, // apb enable
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output reg pready, // apb ready
	output reg pslverr, // apb error, unmapped address
	output reg irq, // level interrupt
	output reg wake_req // level wakeup to power management
);

////////////////////////////////////////////////////////////////////////////
// prescaler

wire tick;

// runs from its own crystal; no processor sleep input gates it
rtc_prescale #(
	.DIV(PRESCALE)
) u_ps (
	.clk(clk),
	.rst_n(rst_n),
	.xtal_clk(xtal_clk),
	.tick(tick)
);

////////////////////////////////////////////////////////////////////////////
// apb decode

wire acc;
wire wr;
wire rd;
wire hit_time;
wire hit_ctrl;
wire hit_alarm;
wire hit_sw;
wire hit_stat;
wire hit_mask;
wire hit_wake;
wire mapped;

// one wait state: pready rises in the second access cycle
assign acc = psel & penable & pready;
assign wr = acc & pwrite & mapped;
assign rd = acc & ~pwrite & mapped;
assign hit_time = (paddr == `RTC_OFS_TIME);
assign hit_ctrl = (paddr == `RTC_OFS_CTRL);
assign hit_alarm = (paddr == `RTC_OFS_ALARM);
assign hit_sw = (paddr == `RTC_OFS_SWATCH);
assign hit_stat = (paddr == `RTC_OFS_STAT);
assign hit_mask = (paddr == `RTC_OFS_MASK);
assign hit_wake = (paddr == `RTC_OFS_WAKE);
assign mapped = hit_time | hit_ctrl | hit_alarm | hit_sw | hit_stat |
	hit_mask | hit_wake;

////////////////////////////////////////////////////////////////////////////
// registers

reg [5:0] sec_reg;
reg [5:0] min_reg;
reg [4:0] hour_reg;
reg [14:0] day_reg;
reg [`RTC_CTRL_W-1:0] ctrl_reg;
reg [31:0] alarm_reg;
reg [SW_W-1:0] sw_reg;
reg sw_armed_reg;
reg [`RTC_EV_W-1:0] stat_reg;
reg [`RTC_EV_W-1:0] mask_reg;
reg [`RTC_EV_W-1:0] wake_reg;
reg [`RTC_EV_W-1:0] clr_reg;
reg match_tod_d_reg;
reg match_day_d_reg;

wire sec_wrap;
wire min_wrap;
wire hour_wrap;
wire [31:0] time_word;
wire match_tod;
wire match_day;
wire sw_under;
wire [`RTC_EV_W-1:0] events;

assign sec_wrap = tick & (sec_reg == `RTC_SEC_LAST);
assign min_wrap = sec_wrap & (min_reg == `RTC_MIN_LAST);
assign hour_wrap = min_wrap & (hour_reg == `RTC_HOUR_LAST);
assign time_word = {day_reg, hour_reg, min_reg, sec_reg};

// time-of-day match ignores the day field; full match adds it
assign match_tod =
	(sec_reg == alarm_reg[`RTC_SEC_MSB:`RTC_SEC_LSB]) &
	(min_reg == alarm_reg[`RTC_MIN_MSB:`RTC_MIN_LSB]) &
	(hour_reg == alarm_reg[`RTC_HOUR_MSB:`RTC_HOUR_LSB]);
assign match_day = match_tod &
	(day_reg == alarm_reg[`RTC_DAY_MSB:`RTC_DAY_LSB]);

// underflow: a tick arriving while the armed count is already zero
assign sw_under = tick & ctrl_reg[`RTC_CTRL_SW_EN] & sw_armed_reg &
	(sw_reg == {SW_W{1'b0}});

// fire on entering a match, so a held match does not refire each cycle
assign events[`RTC_EV_SEC] = tick;
assign events[`RTC_EV_MIN] = sec_wrap;
assign events[`RTC_EV_HOUR] = min_wrap;
assign events[`RTC_EV_DAY] = hour_wrap;
assign events[`RTC_EV_ALM_TOD] = ctrl_reg[`RTC_CTRL_ALM_TOD] & match_tod &
	~match_tod_d_reg;
assign events[`RTC_EV_ALM_DAY] = ctrl_reg[`RTC_CTRL_ALM_DAY] & match_day &
	~match_day_d_reg;
assign events[`RTC_EV_SW] = sw_under;

////////////////////////////////////////////////////////////////////////////
// time counters; a software write wins over a tick in the same cycle

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		sec_reg <= 6'h00;
		min_reg <= 6'h00;
		hour_reg <= 5'h00;
		day_reg <= 15'h0000;
	end else if (wr & hit_time) begin
		sec_reg <= pwdata[`RTC_SEC_MSB:`RTC_SEC_LSB];
		min_reg <= pwdata[`RTC_MIN_MSB:`RTC_MIN_LSB];
		hour_reg <= pwdata[`RTC_HOUR_MSB:`RTC_HOUR_LSB];
		day_reg <= pwdata[`RTC_DAY_MSB:`RTC_DAY_LSB];
	end else if (tick) begin
		if (sec_wrap) begin
			sec_reg <= 6'h00;
			if (min_wrap) begin
				min_reg <= 6'h00;
				if (hour_wrap) begin
					hour_reg <= 5'h00;
					if (day_reg == `RTC_DAY_LAST)
						day_reg <= 15'h0000;
					else
						day_reg <= day_reg + 15'h0001;
				end else begin
					hour_reg <= hour_reg + 5'h01;
				end
			end else begin
				min_reg <= min_reg + 6'h01;
			end
		end else begin
			sec_reg <= sec_reg + 6'h01;
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// stopwatch

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		sw_reg <= {SW_W{1'b0}};
		sw_armed_reg <= 1'b0;
	end else if (wr & hit_sw) begin
		sw_reg <= pwdata[SW_W-1:0];
		sw_armed_reg <= 1'b1;
	end else if (tick & ctrl_reg[`RTC_CTRL_SW_EN]) begin
		if (sw_reg != {SW_W{1'b0}})
			sw_reg <= sw_reg - {{(SW_W-1){1'b0}}, 1'b1};
		else
			sw_armed_reg <= 1'b0; // one interrupt per load
	end
end

////////////////////////////////////////////////////////////////////////////
// control registers

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		ctrl_reg <= `RTC_RST_CTRL;
		alarm_reg <= `RTC_RST_ALARM;
		mask_reg <= `RTC_RST_MASK;
		wake_reg <= `RTC_RST_WAKE;
		match_tod_d_reg <= 1'b0;
		match_day_d_reg <= 1'b0;
	end else begin
		match_tod_d_reg <= match_tod;
		match_day_d_reg <= match_day;
		if (wr & hit_ctrl)
			ctrl_reg <= pwdata[`RTC_CTRL_W-1:0];
		if (wr & hit_alarm)
			alarm_reg <= pwdata;
		if (wr & hit_mask)
			mask_reg <= pwdata[`RTC_EV_W-1:0];
		if (wr & hit_wake)
			wake_reg <= pwdata[`RTC_EV_W-1:0];
	end
end

////////////////////////////////////////////////////////////////////////////
// sticky status: read clears the bits set as it completes, even an event that arrived after the data was sampled; a later event wins

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		stat_reg <= {`RTC_EV_W{1'b0}};
		clr_reg <= {`RTC_EV_W{1'b0}};
	end else begin
		clr_reg <= (rd & hit_stat) ? stat_reg : {`RTC_EV_W{1'b0}};
		stat_reg <= (stat_reg & ~clr_reg) | events;
	end
end

////////////////////////////////////////////////////////////////////////////
// interrupt and wakeup outputs

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		irq <= 1'b0;
		wake_req <= 1'b0;
	end else begin
		irq <= |(stat_reg & ~clr_reg & mask_reg);
		// one level serves sleep, deep sleep and hibernate exit
		wake_req <= |(stat_reg & ~clr_reg & wake_reg);
	end
end

////////////////////////////////////////////////////////////////////////////
// apb response

reg [31:0] rdata_next;

always @* begin
	rdata_next = 32'h00000000;
	case (1'b1)
		hit_time: rdata_next = time_word;
		hit_ctrl: rdata_next[`RTC_CTRL_W-1:0] = ctrl_reg;
		hit_alarm: rdata_next = alarm_reg;
		hit_sw: rdata_next[SW_W-1:0] = sw_reg;
		hit_stat: rdata_next[`RTC_EV_W-1:0] = stat_reg & ~clr_reg;
		hit_mask: rdata_next[`RTC_EV_W-1:0] = mask_reg;
		hit_wake: rdata_next[`RTC_EV_W-1:0] = wake_reg;
		default: rdata_next = 32'h00000000;
	endcase
end

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
	end else begin
		pready <= psel & penable & ~pready;
		pslverr <= psel & penable & ~pready & ~mapped;
		if (psel & penable & ~pready & ~pwrite)
			prdata <= rdata_next;
	end
end

endmodule // rtc_top

// ===== test/rtc_xtal_model.sv
`timescale 1ns/1ps
module rtc_xtal_model #(
	parameter int HALF_NS = 240 // shortened; edges meet only falling clk edges, never rising ones
) (
	output logic xtal_clk // free-running crystal
);
	initial xtal_clk = 1'b0;
	// a crystal never stops, whatever the processor does
	always #(HALF_NS) xtal_clk = ~xtal_clk;
endmodule // rtc_xtal_model

// ===== test/rtc_top_checker.sv
`timescale 1ns/1ps
`include "rtc_defs.vh"
module rtc_top_checker (
	input logic clk, // clock
	input logic rst_n, // reset
	input logic psel, // apb
	input logic penable, // apb
	input logic pwrite, // apb
	input logic [11:0] paddr, // apb
	input logic [31:0] prdata, // apb
	input logic pready, // apb
	input logic pslverr, // apb
	input logic irq, // interrupt
	input logic wake_req // wakeup
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_done;
		psel && penable && pready;
	endsequence
	a_ready_wait: assert property (
		s_setup |-> !pready ##1 !pready ##1 s_done)
		else $error("ready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_access: assert property (
		pready |-> s_done and $past(psel && penable))
		else $error("ready outside access phase");
	a_err_map: assert property (
		s_done and paddr[1:0] == 2'h0 |->
		pslverr == (paddr > `RTC_OFS_WAKE))
		else $error("error flag wrong for address");
	a_err_zero: assert property (pslverr && !pwrite |-> prdata == 0)
		else $error("unmapped read not zero");
	a_data_read: assert property (!$stable(prdata) |-> pready && !pwrite)
		else $error("read data moved without read");
	// status only clears, and mask only changes, through the bus
	a_irq_fall: assert property (
		$fell(irq) |-> $past(pready) || $past(pready, 2) || $past(pready, 3))
		else $error("interrupt dropped without access");
	a_quiet_reset: assert property (
		$rose(rst_n) |-> !irq && !wake_req && !pready)
		else $error("outputs active after reset");
endmodule // rtc_top_checker
bind rtc_top rtc_top_checker chk_u (.clk(clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .wake_req(wake_req));

// ===== test/test_rtc_top.sv
`timescale 1ns/1ps
`include "rtc_defs.vh"
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin n_mismatch++; \
	$display("wrong value t=%0t got %h exp %h", $time, (g), (x)); end end
module test_rtc_watch_alarm_stopwatch;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r, t;
	logic xtal_clk, pready, pslverr, irq, wake_req, e;
	logic [35:0] ex;
	int n_mismatch = 0, comparisons = 0, k, i;
	always #25 clk = ~clk;
	rtc_xtal_model xo_u (.xtal_clk(xtal_clk));
	rtc_top #(.PRESCALE(4)) dut_u (.clk(clk), .rst_n(rst_n),
		.xtal_clk(xtal_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .wake_req(wake_req));
	////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1 && n < 50);
		`CHK(pready, 1'b1)
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wt(input logic w);
		k = 0;
		do begin
			@(posedge clk);
			k++;
		// skip the stale level left by a status read that just completed
		end while ((k < 2 || (w ? wake_req : irq) !== 1) && k < 400);
	endtask
	function automatic logic [35:0] nxt(input logic [31:0] v);
		logic [5:0] s, m;
		logic [4:0] h;
		logic [14:0] d;
		logic [3:0] ev;
		{d, h, m, s} = v;
		ev = 4'h1;
		if (s == 59) begin
			s = 0;
			ev[1] = 1;
			if (m == 59) begin
				m = 0;
				ev[2] = 1;
				if (h == 23) begin
					h = 0;
					ev[3] = 1;
					d++; // top day rolls to zero
				end else
					h++;
			end else
				m++;
		end else
			s++;
		return {ev, d, h, m, s};
	endfunction
	task results;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		n_mismatch++;
		results;
	end
	initial begin
		void'($urandom(77));
		repeat (16) @(posedge clk);
		rst_n <= 1;
		// time and status skipped: the first tick may already land
		for (i = 1; i < 7; i++) begin
			if (i != 4) begin
				apb(0, 12'(i * 4), 0);
				`CHK(r, 32'h0)
			end
		end
		apb(0, 12'h01c, 0);
		`CHK({e, r}, {1'b1, 32'h0})
		$display("test reset done");
		apb(1, `RTC_OFS_MASK, 32'h1);
		apb(1, `RTC_OFS_CTRL, 32'h3);
		apb(0, `RTC_OFS_STAT, 0);
		for (i = 0; i < 6; i++) begin
			t = {15'($urandom), 5'($urandom % 24), 6'($urandom % 60),
				6'($urandom % 60)};
			if (i == 0)
				t = 32'hffff7efb;
			if (i == 1)
				t = 32'h00003efb;
			ex = nxt(t);
			// sync to a tick so both writes land before the next one
			wt(0);
			apb(0, `RTC_OFS_STAT, 0);
			apb(1, `RTC_OFS_ALARM, ex[31:0] ^ {14'h0, i[0], 17'h0});
			apb(1, `RTC_OFS_TIME, t);
			wt(0);
			`CHK(irq, 1'b1)
			apb(0, `RTC_OFS_TIME, 0);
			`CHK(r, ex[31:0])
			apb(0, `RTC_OFS_STAT, 0);
			`CHK(r, {25'h0, 1'b0, ~i[0], 1'b1, ex[35:32]})
		end
		$display("test time and alarm done");
		wt(0);
		apb(0, `RTC_OFS_STAT, 0);
		apb(1, `RTC_OFS_CTRL, 32'h4);
		apb(1, `RTC_OFS_MASK, 32'h40);
		apb(1, `RTC_OFS_WAKE, 32'h40);
		apb(1, `RTC_OFS_SWATCH, 32'h2);
		wt(1);
		`CHK(k > 70 && k < 125, 1'b1)
		`CHK(irq, 1'b1)
		apb(0, `RTC_OFS_STAT, 0);
		`CHK(r[6], 1'b1)
		repeat (3) @(posedge clk);
		`CHK({irq, wake_req}, 2'b00)
		$display("test stopwatch done");
		apb(1, `RTC_OFS_MASK, 0);
		apb(1, `RTC_OFS_WAKE, 1);
		wt(1);
		`CHK({irq, wake_req}, 2'b01)
		$display("test wakeup done");
		results;
	end
endmodule // test_rtc_watch_alarm_stopwatch
